// ### shared/pwm_time_bases_regs.svh
/*
 Register map, field positions and reset values of the PWM master time bases.
 Assumes inclusion by bare name from files that need the numbers.
*/
`ifndef PWM_TIME_BASES_REGS_SVH
`define PWM_TIME_BASES_REGS_SVH

// Byte addresses on the AXI4-Lite bus
`define ADDR_PRIMARY_COUNT 8'h00
`define ADDR_SECONDARY_CONTROL 8'h04
`define ADDR_SECONDARY_PERIOD 8'h08
`define ADDR_IRQ_STATUS 8'h0C
`define ADDR_IRQ_CLEAR 8'h10
`define ADDR_IRQ_ENABLE 8'h14

// Secondary control fields
`define CTL_PENDING_BIT 12
`define CTL_IRQ_EN_BIT 11
`define CTL_PRESCALE_HI 6
`define CTL_PRESCALE_LO 4
`define CTL_POSTSCALE_HI 3
`define CTL_POSTSCALE_LO 0

// Interrupt status fields
`define IRQ_SEC_EVENT_BIT 0
`define IRQ_PRI_WRAP_BIT 1
`define IRQ_SEC_WRAP_BIT 2
`define IRQ_WIDTH 3

// Reset values
`define RST_SECONDARY_PERIOD 16'h4020
`define RST_PRESCALE 3'h0
`define RST_POSTSCALE 4'h0

// Shortest effective period
`define MIN_PERIOD 16'h0008

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### shared/pwm_time_bases_pkg.sv
/*
 Types shared by the PWM master time base files.
 Assumes nothing of its surroundings.
*/
package pwm_time_bases_pkg;
	typedef logic [15:0] count_t;
	typedef logic [2:0] prescale_t;
	typedef logic [3:0] postscale_t;
	typedef logic [7:0] addr_t;
endpackage : pwm_time_bases_pkg

// ### src/clock_prescaler.sv
/*
 Power-of-two clock prescaler: one-cycle tick every 2^sel cycles of aclk.
 Assumes a synchronous active-low reset and a level enable.
*/
`timescale 1ns/1ps
`default_nettype none
module clock_prescaler
	import pwm_time_bases_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic enable,
	input wire prescale_t div_sel,
	output logic tick
);
	logic [6:0] div_cnt_q;
	wire logic [7:0] one_hot = 8'h01 << div_sel;
	wire logic [6:0] div_mask = 7'(one_hot - 8'h01);

	assign tick = enable && ((div_cnt_q & div_mask) == 7'h00);

	always_ff @(posedge aclk) begin
		if (!aresetn || !enable) begin
			div_cnt_q <= 7'h00;
		end else begin
			div_cnt_q <= div_cnt_q + 7'h01;
		end
	end
endmodule : clock_prescaler
`default_nettype wire

// ### src/master_timebase.sv
/*
 One master time base counter with period wrap and minimum-period clamp.
 Assumes tick is a one-cycle enable from a prescaler on aclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pwm_time_bases_regs.svh"
module master_timebase
	import pwm_time_bases_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic enable,
	input wire logic tick,
	input wire count_t period,
	output count_t count,
	output logic wrap
);
	count_t count_q;
	wire count_t eff_period = (period < `MIN_PERIOD) ? `MIN_PERIOD : period;
	wire logic at_period = (count_q >= eff_period);

	assign count = count_q;
	assign wrap = enable && tick && at_period;

	always_ff @(posedge aclk) begin
		if (!aresetn || !enable) begin
			count_q <= 16'h0000;
		end else if (tick) begin
			count_q <= at_period ? 16'h0000 : count_q + 16'h0001;
		end
	end
endmodule : master_timebase
`default_nettype wire

// ### src/pwm_master_time_bases.sv
/*
 PWM primary and secondary master time bases with AXI4-Lite registers,
 special-event postscaler and a level interrupt.
 Assumes primary control, period and compare settings arrive as ports
 from the surrounding PWM unit; one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pwm_time_bases_regs.svh"

// Summary of operation
// - Primary counter steps each prescaled clock to period
// - Primary count reads 16 bits, upper zero
// - Control bits 31-13 and 10-7 read zero
// - Bit 12 shows secondary event pending
// - Bit 11 enables secondary event interrupt
// - Bits 6-4 divide clock by 1 to 128
// - Bits 3-0 trigger every N+1 compare matches
// - Pending clears once enable and flag cleared
// - Flag clear ignored while interrupt enable set
// - Secondary period 16-bit read/write, upper zero
// - Period below 8 acts as 8
// - Secondary counter steps each prescaled clock to period
// - Secondary compare match yields special-event trigger
module pwm_master_time_bases
	import pwm_time_bases_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic global_timebase_enable,
	input wire prescale_t primary_clock_prescale,
	input wire count_t primary_timebase_period,
	input wire count_t secondary_event_compare,
	output logic primary_period_match,
	output logic secondary_event_trigger,
	output count_t secondary_timebase_count,
	output logic irq
);
	// Register state
	logic secondary_event_pending_q;
	logic secondary_event_irq_enable_q;
	prescale_t secondary_clock_prescale_q;
	postscale_t trigger_postscale_select_q;
	count_t secondary_timebase_period_q;
	logic [`IRQ_WIDTH-1:0] irq_status_q;
	logic [`IRQ_WIDTH-1:0] irq_enable_q;
	logic irq_q;
	postscale_t postscale_cnt_q;
	logic trigger_q;
	logic pri_match_q;
	count_t sec_count_q;

	// Write channel state
	logic aw_have_q;
	addr_t awaddr_q;
	logic w_have_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;

	// Read channel state
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	// Time base wiring
	logic pri_tick;
	logic sec_tick;
	count_t pri_count;
	count_t sec_count;
	logic pri_wrap;
	logic sec_wrap;

	clock_prescaler u_pri_prescaler (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(global_timebase_enable),
		.div_sel(primary_clock_prescale),
		.tick(pri_tick)
	);

	master_timebase u_pri_timebase (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(global_timebase_enable),
		.tick(pri_tick),
		.period(primary_timebase_period),
		.count(pri_count),
		.wrap(pri_wrap)
	);

	clock_prescaler u_sec_prescaler (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(global_timebase_enable),
		.div_sel(secondary_clock_prescale_q),
		.tick(sec_tick)
	);

	master_timebase u_sec_timebase (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(global_timebase_enable),
		.tick(sec_tick),
		.period(secondary_timebase_period_q),
		.count(sec_count),
		.wrap(sec_wrap)
	);

	// Compare match and postscaler
	wire logic compare_event = global_timebase_enable && sec_tick && (sec_count == secondary_event_compare);
	wire logic postscale_done = (postscale_cnt_q == trigger_postscale_select_q);
	wire logic fire = compare_event && postscale_done;

	// Write channel decode
	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready = !w_have_q && !bvalid_q;
	wire logic aw_take = s_axi_awvalid && s_axi_awready;
	wire logic w_take = s_axi_wvalid && s_axi_wready;
	wire logic aw_ok = aw_have_q || aw_take;
	wire logic w_ok = w_have_q || w_take;
	wire logic do_write = aw_ok && w_ok && !bvalid_q;
	wire addr_t wr_addr = aw_have_q ? awaddr_q : s_axi_awaddr;
	wire logic [31:0] wr_data = w_have_q ? wdata_q : s_axi_wdata;
	wire logic [3:0] wr_strb = w_have_q ? wstrb_q : s_axi_wstrb;
	wire logic [31:0] wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
	wire logic [31:0] wr_bits = wr_data & wr_mask;

	wire logic wr_count = do_write && (wr_addr == `ADDR_PRIMARY_COUNT);
	wire logic wr_ctrl = do_write && (wr_addr == `ADDR_SECONDARY_CONTROL);
	wire logic wr_period = do_write && (wr_addr == `ADDR_SECONDARY_PERIOD);
	wire logic wr_status = do_write && (wr_addr == `ADDR_IRQ_STATUS);
	wire logic wr_clear = do_write && (wr_addr == `ADDR_IRQ_CLEAR);
	wire logic wr_enable = do_write && (wr_addr == `ADDR_IRQ_ENABLE);
	wire logic wr_hit = wr_count || wr_ctrl || wr_period || wr_status || wr_clear || wr_enable;

	// Register read images
	wire logic [31:0] ctrl_image = {19'h00000, secondary_event_pending_q, secondary_event_irq_enable_q,
		4'h0, secondary_clock_prescale_q, trigger_postscale_select_q};
	wire logic [31:0] period_image = {16'h0000, secondary_timebase_period_q};
	wire logic [31:0] count_image = {16'h0000, pri_count};
	wire logic [31:0] status_image = {29'h00000000, irq_status_q};
	wire logic [31:0] enable_image = {29'h00000000, irq_enable_q};

	// Merged write values
	wire logic [31:0] ctrl_merged = (ctrl_image & ~wr_mask) | wr_bits;
	wire logic [31:0] period_merged = (period_image & ~wr_mask) | wr_bits;
	wire logic [31:0] enable_merged = (enable_image & ~wr_mask) | wr_bits;

	// Interrupt status update; set wins over clear
	wire logic [`IRQ_WIDTH-1:0] irq_events = {sec_wrap, pri_wrap, fire && secondary_event_irq_enable_q};
	wire logic [`IRQ_WIDTH-1:0] clear_req = wr_clear ? wr_bits[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};
	wire logic [`IRQ_WIDTH-1:0] clear_blk = {{(`IRQ_WIDTH-1){1'b0}}, secondary_event_irq_enable_q};
	wire logic [`IRQ_WIDTH-1:0] clear_eff = clear_req & ~clear_blk;
	wire logic [`IRQ_WIDTH-1:0] irq_status_d = (irq_status_q & ~clear_eff) | irq_events;

	// Pending status follows the secondary flag and enable
	wire logic pend_set = fire && secondary_event_irq_enable_q;
	wire logic pend_release = !secondary_event_irq_enable_q && !irq_status_q[`IRQ_SEC_EVENT_BIT];
	wire logic secondary_event_pending_d = pend_set || (secondary_event_pending_q && !pend_release);

	// Read channel decode
	assign s_axi_arready = !rvalid_q;
	wire logic ar_take = s_axi_arvalid && s_axi_arready;
	wire logic rd_count = (s_axi_araddr == `ADDR_PRIMARY_COUNT);
	wire logic rd_ctrl = (s_axi_araddr == `ADDR_SECONDARY_CONTROL);
	wire logic rd_period = (s_axi_araddr == `ADDR_SECONDARY_PERIOD);
	wire logic rd_status = (s_axi_araddr == `ADDR_IRQ_STATUS);
	wire logic rd_clear = (s_axi_araddr == `ADDR_IRQ_CLEAR);
	wire logic rd_enable = (s_axi_araddr == `ADDR_IRQ_ENABLE);
	wire logic rd_hit = rd_count || rd_ctrl || rd_period || rd_status || rd_clear || rd_enable;
	wire logic [31:0] rd_data = rd_count ? count_image :
		rd_ctrl ? ctrl_image :
		rd_period ? period_image :
		rd_status ? status_image :
		rd_enable ? enable_image : 32'h00000000;

	// Outputs
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign primary_period_match = pri_match_q;
	assign secondary_event_trigger = trigger_q;
	assign secondary_timebase_count = sec_count_q;
	assign irq = irq_q;

	// Write address and data holding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			awaddr_q <= 8'h00;
		end else if (do_write) begin
			aw_have_q <= 1'b0;
		end else if (aw_take) begin
			aw_have_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q <= 1'b0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else if (do_write) begin
			w_have_q <= 1'b0;
		end else if (w_take) begin
			w_have_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end
	end

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= `RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Read response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `RESP_OKAY;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_data;
			rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Secondary control fields
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			secondary_event_irq_enable_q <= 1'b0;
			secondary_clock_prescale_q <= `RST_PRESCALE;
			trigger_postscale_select_q <= `RST_POSTSCALE;
		end else if (wr_ctrl) begin
			secondary_event_irq_enable_q <= ctrl_merged[`CTL_IRQ_EN_BIT];
			secondary_clock_prescale_q <= ctrl_merged[`CTL_PRESCALE_HI:`CTL_PRESCALE_LO];
			trigger_postscale_select_q <= ctrl_merged[`CTL_POSTSCALE_HI:`CTL_POSTSCALE_LO];
		end
	end

	// Secondary period
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			secondary_timebase_period_q <= `RST_SECONDARY_PERIOD;
		end else if (wr_period) begin
			secondary_timebase_period_q <= period_merged[15:0];
		end
	end

	// Interrupt flags, enables and pending status
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_q <= {`IRQ_WIDTH{1'b0}};
			irq_enable_q <= {`IRQ_WIDTH{1'b0}};
			secondary_event_pending_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			irq_status_q <= irq_status_d;
			secondary_event_pending_q <= secondary_event_pending_d;
			irq_q <= |(irq_status_d & (wr_enable ? enable_merged[`IRQ_WIDTH-1:0] : irq_enable_q));
			if (wr_enable) begin
				irq_enable_q <= enable_merged[`IRQ_WIDTH-1:0];
			end
		end
	end

	// Postscaler and registered event outputs
	always_ff @(posedge aclk) begin
		if (!aresetn || !global_timebase_enable) begin
			postscale_cnt_q <= 4'h0;
		end else if (compare_event) begin
			postscale_cnt_q <= postscale_done ? 4'h0 : postscale_cnt_q + 4'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trigger_q <= 1'b0;
			pri_match_q <= 1'b0;
			sec_count_q <= 16'h0000;
		end else begin
			trigger_q <= fire;
			pri_match_q <= pri_wrap;
			sec_count_q <= sec_count;
		end
	end
endmodule : pwm_master_time_bases
`default_nettype wire

// ### testbench/pwm_master_time_bases_properties.sv
/*
 Port assertions for the PWM master time bases.
 Assumes a bind onto the top module; one clock, reset active low.
*/
`timescale 1ns/1ps
`default_nettype none
module pwm_master_time_bases_properties
	import pwm_time_bases_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic global_timebase_enable,
	input wire count_t secondary_event_compare,
	input wire logic primary_period_match,
	input wire logic secondary_event_trigger,
	input wire count_t secondary_timebase_count
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read response dropped");
	property p_r_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_answer: assert property (p_r_answer) else $error("read answer late");
	property p_upper_zero;
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
	property p_count_step;
		global_timebase_enable && secondary_timebase_count != $past(secondary_timebase_count)
			|-> secondary_timebase_count == $past(secondary_timebase_count) + 16'h0001
			|| secondary_timebase_count == 16'h0000;
	endproperty
	a_count_step: assert property (p_count_step) else $error("count jumped");
	property p_halt_zero;
		!global_timebase_enable ##1 !global_timebase_enable |=> secondary_timebase_count == 16'h0000;
	endproperty
	a_halt_zero: assert property (p_halt_zero) else $error("count held while off");
	property p_match_gap;
		primary_period_match |=> !primary_period_match [*8];
	endproperty
	a_match_gap: assert property (p_match_gap) else $error("period shorter than minimum");
	property p_trig_at_compare;
		secondary_event_trigger |-> secondary_timebase_count == secondary_event_compare;
	endproperty
	a_trig_at_compare: assert property (p_trig_at_compare) else $error("trigger off compare");
endmodule : pwm_master_time_bases_properties
bind pwm_master_time_bases pwm_master_time_bases_properties u_props (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.global_timebase_enable(global_timebase_enable),
	.secondary_event_compare(secondary_event_compare),
	.primary_period_match(primary_period_match),
	.secondary_event_trigger(secondary_event_trigger),
	.secondary_timebase_count(secondary_timebase_count)
);
`default_nettype wire

// ### testbench/pwm_master_time_bases_tb.sv
/*
 Self-checking bench for the PWM master time bases.
 Assumes package, register header, design and checker compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pwm_time_bases_regs.svh"
module pwm_master_time_bases_tb
	import pwm_time_bases_pkg::*;
;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic global_timebase_enable = 1'h0;
	logic primary_period_match, secondary_event_trigger, irq;
	prescale_t primary_clock_prescale = 3'h0;
	// Below the minimum so the period-gap check sees the clamp
	count_t primary_timebase_period = 16'h0003, secondary_event_compare = 16'h0000;
	count_t secondary_timebase_count;
	int errors = 0, n_compared = 0, seed = 32'h6424655f;

	pwm_master_time_bases dut (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(s_axi_awprot),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(s_axi_arprot),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.global_timebase_enable(global_timebase_enable),
		.primary_clock_prescale(primary_clock_prescale),
		.primary_timebase_period(primary_timebase_period),
		.secondary_event_compare(secondary_event_compare),
		.primary_period_match(primary_period_match),
		.secondary_event_trigger(secondary_event_trigger),
		.secondary_timebase_count(secondary_timebase_count),
		.irq(irq)
	);

	always #4 aclk = ~aclk;

	task automatic summarize();
		$display("Compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		logic ta, tw, tb;
		logic [1:0] r;
		int t;
		tb = 1'h0;
		t = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!tb && t < 200) begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid === 1'h1;
			r = s_axi_bresp;
			t++;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
		end
		s_axi_bready <= 1'h0;
		chk("bresp", er, r);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] q, input logic [1:0] er = 2'h0);
		logic ta, ok;
		logic [1:0] r;
		int t;
		ok = 1'h0;
		t = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		while (!ok && t < 200) begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			ok = s_axi_rvalid === 1'h1;
			q = s_axi_rdata;
			r = s_axi_rresp;
			t++;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'h0;
		end
		s_axi_rready <= 1'h0;
		chk("rresp", er, r);
	endtask : rd

	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		rd(a, q);
		chk(nm, e, q);
	endtask : rc

	// Cycles between two events: 0 trigger, 1 primary wrap, 2 count entering 1
	task automatic gap(input int md, output int n, output int m);
		int k, t;
		count_t v;
		logic hit;
		n = 0;
		k = 0;
		t = 0;
		m = 0;
		v = 16'h0000;
		while (k < 2 && t < 3000) begin
			@(negedge aclk);
			t++;
			hit = md == 0 ? secondary_event_trigger : md == 1 ? primary_period_match
				: secondary_timebase_count == 16'h0001 && v != 16'h0001;
			v = secondary_timebase_count;
			if (v > m) m = v;
			if (hit === 1'h1) k++;
			else if (k == 1) n++;
		end
		// Return on a rising edge so callers drive inputs there
		@(posedge aclk);
	endtask : gap

	initial begin
		repeat (40000) @(posedge aclk);
		errors++;
		summarize();
	end

	initial begin
		logic [31:0] q, d;
		int n, m, p, s, i;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		rc("pcount", `ADDR_PRIMARY_COUNT, 32'h0);
		rc("ctl", `ADDR_SECONDARY_CONTROL, 32'h0);
		rc("period", `ADDR_SECONDARY_PERIOD, 32'h0000_4020);
		rc("irqen", `ADDR_IRQ_ENABLE, 32'h0);
		rd(8'h18, q, `RESP_SLVERR);
		chk("unmapped", 32'h0, q);
		wr(8'h18, 32'hFFFF_FFFF, `RESP_SLVERR);
		d = $random(seed);
		wr(`ADDR_SECONDARY_CONTROL, d);
		rc("ctl", `ADDR_SECONDARY_CONTROL, d & 32'h0000_087F);
		d = $random(seed);
		wr(`ADDR_SECONDARY_PERIOD, d);
		rc("period", `ADDR_SECONDARY_PERIOD, d & 32'h0000_FFFF);
		wr(`ADDR_SECONDARY_PERIOD, 32'h3);
		for (p = 0; p < 8; p++) begin
			global_timebase_enable <= 1'h0;
			wr(`ADDR_SECONDARY_CONTROL, p << 4);
			global_timebase_enable <= 1'h1;
			gap(2, n, m);
			chk("divide", (9 << p) - 1, n);
			chk("maxcount", 8, m);
		end
		for (i = 0; i < 3; i++) begin
			s = i == 0 ? 0 : i == 1 ? 15 : {$random(seed)} % 15;
			global_timebase_enable <= 1'h0;
			wr(`ADDR_SECONDARY_CONTROL, s);
			secondary_event_compare <= count_t'({$random(seed)} % 9);
			global_timebase_enable <= 1'h1;
			gap(0, n, m);
			chk("postscale", 9 * (s + 1) - 1, n);
		end
		p = {$random(seed)} % 4;
		s = {$random(seed)} % 21;
		global_timebase_enable <= 1'h0;
		primary_clock_prescale <= prescale_t'(p);
		primary_timebase_period <= count_t'(s);
		if (s < 8) s = 8;
		@(posedge aclk);
		global_timebase_enable <= 1'h1;
		gap(1, n, m);
		chk("pwrap", ((s + 1) << p) - 1, n);
		rd(`ADDR_PRIMARY_COUNT, q);
		chk("pcount", 32'h1, q <= s);
		global_timebase_enable <= 1'h0;
		wr(`ADDR_SECONDARY_CONTROL, 32'h0000_0800);
		global_timebase_enable <= 1'h1;
		gap(0, n, m);
		chk("masked", 32'h0, irq);
		wr(`ADDR_IRQ_ENABLE, 32'h1);
		// Stop new events so the clear attempts below are seen alone
		global_timebase_enable <= 1'h0;
		@(negedge aclk);
		chk("irq", 32'h1, irq);
		rc("ctl", `ADDR_SECONDARY_CONTROL, 32'h0000_1800);
		wr(`ADDR_IRQ_CLEAR, 32'h1);
		rd(`ADDR_IRQ_STATUS, q);
		chk("flag", 32'h1, q[0]);
		wr(`ADDR_SECONDARY_CONTROL, 32'h0);
		rc("ctl", `ADDR_SECONDARY_CONTROL, 32'h0000_1000);
		wr(`ADDR_IRQ_CLEAR, 32'h1);
		rd(`ADDR_IRQ_STATUS, q);
		chk("flag", 32'h0, q[0]);
		rc("ctl", `ADDR_SECONDARY_CONTROL, 32'h0);
		chk("irq", 32'h0, irq);
		summarize();
	end
endmodule : pwm_master_time_bases_tb
`default_nettype wire
